// >>> test/bpm_micro_model.sv
`timescale 1ns/1ps
module bpm_micro_model (
  input  wire logic       clk_i,
  input  wire logic       run_i,
  input  wire logic [7:0] half_i,
  output logic            low_o,
  output logic            high_o
);
  logic [7:0] cnt_r;

  // ==========================================================================
  // Complementary half-bridge drive
  // Complementary toggling, stops low
  always_ff @(posedge clk_i) begin
    if (!run_i) begin
      cnt_r  <= 8'h00;
      low_o  <= 1'b0;
      high_o <= 1'b0;
    end else if (cnt_r >= half_i) begin
      cnt_r  <= 8'h00;
      low_o  <= !low_o;
      high_o <= low_o;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule : bpm_micro_model

// >>> test/bpm_power_mode_controller_props.sv
`timescale 1ns/1ps
module bpm_pmc_props
  import bpm_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  input  wire bpm_cmp_t  cmp_i,
  input  wire bpm_gate_t gate_in_i,
  input  wire bpm_gate_t gate_out_o,
  input  wire logic      current_fault_out_o,
  input  wire logic      startup_source_on_o,
  input  wire logic      ref_enable_o,
  input  wire logic      ref_high_current_o,
  input  wire logic      ref_sink_on_o,
  input  wire logic      supply_regulation_switch_o,
  input  wire logic      bootstrap_on_o,
  input  wire logic      boot_reverse_block_o,
  input  wire logic      wb_cyc_i,
  input  wire logic      wb_stb_i,
  input  wire logic      wb_ack_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================================================
  // Pin relations
  a_sink_tracks_ref: assert property (
    ref_sink_on_o == !ref_enable_o) else $error("sink not inverse of reference");
  a_boot_block_on: assert property (
    boot_reverse_block_o) else $error("reverse block released");
  a_boot_follow_low: assert property (
    bootstrap_on_o |-> gate_out_o.low || $past(gate_out_o.low))
    else $error("bootstrap on without low gate");
  a_interlock_low: assert property (
    (gate_in_i.low && gate_in_i.high) [*5] |-> !gate_out_o.low && !gate_out_o.high)
    else $error("interlock failed");
  a_fault_gates_low: assert property (
    current_fault_out_o && $past(current_fault_out_o) |-> !gate_out_o.low && !gate_out_o.high)
    else $error("gates high during fault");
  a_fault_when_oper: assert property (
    current_fault_out_o |-> ref_high_current_o || $past(ref_high_current_o))
    else $error("fault outside operating");
  a_oper_source_off: assert property (
    ref_high_current_o && $past(ref_high_current_o) |-> !startup_source_on_o && ref_enable_o)
    else $error("operating outputs wrong");
  a_idle_gates_low: assert property (
    !ref_high_current_o && !$past(ref_high_current_o) |-> gate_out_o == 4'h0)
    else $error("gates driven outside operating");
  a_idle_switch_open: assert property (
    !ref_high_current_o && !$past(ref_high_current_o) |-> !supply_regulation_switch_o)
    else $error("switch closed outside operating");
  a_protect_close: assert property (
    (cmp_i.above_protect && ref_high_current_o) [*5] |-> supply_regulation_switch_o)
    else $error("switch open above protect level");
  a_wb_ack_next: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_wb_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
endmodule : bpm_pmc_props

bind bpm_power_mode_controller bpm_pmc_props u_props (
  .clk_i, .rst_i, .cmp_i, .gate_in_i, .gate_out_o, .current_fault_out_o,
  .startup_source_on_o, .ref_enable_o, .ref_high_current_o, .ref_sink_on_o,
  .supply_regulation_switch_o, .bootstrap_on_o, .boot_reverse_block_o,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o);

// >>> test/tb.sv
`timescale 1ns/1ps
module tb;
  import bpm_pkg::*;
  localparam int TO = 200;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  bpm_cmp_t    cmp_r = '0;
  logic        run_r = 1'b0, lo_r = 1'b0, hi_r = 1'b0, pf_r = 1'b0, he_r = 1'b0;
  logic [7:0]  half_r = 8'h04;
  logic        lo_m, hi_m, fault, src, ren, rhi, sink, supply_regulation_switch, boot, blk, ack;
  bpm_gate_t   gin, gout;
  logic        cyc_r = 1'b0, stb_r = 1'b0, we_r = 1'b0;
  logic [7:0]  adr_r = 8'h00;
  logic [31:0] dat_r = 32'h0, rdat, rd;
  int          n_mismatch = 0;
  int          n_tests = 0;

  assign gin = '{heat: he_r, power_factor: pf_r,
                 high: run_r ? hi_m : hi_r, low: run_r ? lo_m : lo_r};

  initial forever #4 clk_i = !clk_i;

  bpm_micro_model u_micro (.clk_i(clk_i), .run_i(run_r), .half_i(half_r),
                           .low_o(lo_m), .high_o(hi_m));

  bpm_power_mode_controller #(.TIMEOUT_CYCLES(TO)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cmp_i(cmp_r), .gate_in_i(gin), .gate_out_o(gout),
    .current_fault_out_o(fault), .startup_source_on_o(src), .ref_enable_o(ren),
    .ref_high_current_o(rhi), .ref_sink_on_o(sink), .supply_regulation_switch_o(supply_regulation_switch),
    .bootstrap_on_o(boot), .boot_reverse_block_o(blk), .wb_cyc_i(cyc_r),
    .wb_stb_i(stb_r), .wb_we_i(we_r), .wb_adr_i(adr_r), .wb_sel_i(4'hF),
    .wb_dat_i(dat_r), .wb_dat_o(rdat), .wb_ack_o(ack));

  // ==========================================================================
  // Bench tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc_r <= 1'b1;
    stb_r <= 1'b1;
    we_r  <= we;
    adr_r <= a;
    dat_r <= d;
    // Waits for ack with no limit; only the watchdog ends a hung transfer
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1);
    chk(k, 32'd2);
    rd = rdat;
    cyc_r <= 1'b0;
    stb_r <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic mode(input logic [1:0] m);
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[1:0], m);
  endtask : mode

  // Heater also needs its own allow bit; interlock overrides the half-bridge
  function automatic bpm_gate_t exp_gate(input bpm_gate_t g, input logic [1:0] c);
    bpm_gate_t e;
    e = c[0] ? g : 4'h0;
    e.heat = g.heat & (&c);
    if (g.low && g.high) begin
      e.low = 1'b0;
      e.high = 1'b0;
    end
    return e;
  endfunction : exp_gate

  task automatic results;
    $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  // ==========================================================================
  // Watchdog, well above the roughly 3100 cycles of the sequence
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    results();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    logic [1:0] c;
    bpm_gate_t  eg;
    void'($urandom(49284));
    tick(5);
    rst_i <= 1'b0;
    tick(1);
    chk({gout, fault, src, ren, sink, supply_regulation_switch, boot, blk}, 11'h029);
    wb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h3);
    wb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    mode(2'h0);
    cmp_r <= 10'h10F;
    tick(6);
    mode(2'h1);
    chk({src, ren, rhi, sink}, 4'h4);
    cmp_r <= 10'h10C;
    tick(6);
    chk(src, 32'h1);
    cmp_r <= 10'h18F;
    hi_r <= 1'b1;
    tick(4);
    hi_r <= 1'b0;
    tick(6);
    mode(2'h1);
    hi_r <= 1'b1;
    tick(DWELL_CYC);
    hi_r <= 1'b0;
    tick(6);
    mode(2'h2);
    chk({src, rhi}, 2'h1);
    lo_r <= 1'b1;
    hi_r <= 1'b1;
    tick(8);
    chk({gout.low, gout.high, boot}, 3'h0);
    wb(1'b0, ADDR_EVENTS, 32'h0);
    chk(rd, 32'h2);
    for (int i = 0; i < 8; i++) begin
      c = 2'($urandom);
      wb(1'b1, ADDR_CTRL, {30'h0, c});
      hi_r <= 1'($urandom);
      pf_r <= 1'($urandom);
      he_r <= 1'($urandom);
      lo_r <= !lo_r;
      tick(5);
      eg = exp_gate(gin, c);
      chk(gout, eg);
      chk(boot, eg.low);
    end
    wb(1'b1, ADDR_CTRL, 32'h3);
    half_r <= 8'(2 + $urandom_range(18));
    run_r <= 1'b1;
    cmp_r <= 10'h19F;
    tick(10);
    chk(supply_regulation_switch, 32'h1);
    cmp_r <= 10'h18F;
    tick(60);
    chk(supply_regulation_switch, 32'h0);
    cmp_r <= 10'h1EF;
    tick(60);
    chk(supply_regulation_switch, 32'h1);
    wb(1'b1, ADDR_EVENTS, 32'hF);
    cmp_r.cs_above_ref <= 1'b1;
    tick(6);
    chk({fault, gout.low, gout.high}, 3'h4);
    wb(1'b0, ADDR_EVENTS, 32'h0);
    chk(rd, 32'h1);
    cmp_r.cs_above_ref <= 1'b0;
    tick(6);
    chk(fault, 32'h1);
    run_r <= 1'b0;
    lo_r <= 1'b0;
    hi_r <= 1'b0;
    tick(6);
    chk(fault, 32'h0);
    tick(150);
    mode(2'h2);
    tick(60);
    mode(2'h1);
    wb(1'b0, ADDR_EVENTS, 32'h0);
    chk(rd, 32'h9);
    wb(1'b0, ADDR_IDLE, 32'h0);
    chk(rd, 32'h0);
    hi_r <= 1'b1;
    tick(DWELL_CYC);
    hi_r <= 1'b0;
    run_r <= 1'b1;
    tick(6);
    mode(2'h2);
    cmp_r <= 10'h008;
    tick(6);
    mode(2'h3);
    chk({src, ren, rhi}, 3'h6);
    wb(1'b0, ADDR_EVENTS, 32'h0);
    chk(rd, 32'hD);
    cmp_r <= 10'h000;
    tick(6);
    mode(2'h0);
    chk({ren, sink}, 2'h1);
    cmp_r <= 10'h10F;
    tick(6);
    mode(2'h1);
    chk(gout, 4'h0);
    cmp_r <= 10'h000;
    tick(6);
    mode(2'h0);
    wb(1'b1, ADDR_EVENTS, 32'hF);
    wb(1'b0, ADDR_EVENTS, 32'h0);
    chk(rd, 32'h0);
    results();
  end
endmodule : tb

// >>> verilog/bpm_pkg.sv
package bpm_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_MHZ         = 125;
  localparam int DWELL_US        = 10;
  localparam int TIMEOUT_US      = 100;
  localparam int DWELL_CYC       = DWELL_US * CLK_MHZ;
  localparam int TIMEOUT_CYC     = TIMEOUT_US * CLK_MHZ;
  localparam int CNT_W           = 14;

  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_EVENTS = 8'h08;
  localparam logic [7:0] ADDR_IDLE   = 8'h0C;
  localparam int         CTRL_DRV_ALLOW  = 0;
  localparam int         CTRL_HEAT_ALLOW = 1;
  localparam logic [1:0] CTRL_RESET      = 2'h3;
  localparam int         EV_OCP      = 0;
  localparam int         EV_LOCK     = 1;
  localparam int         EV_SHUT     = 2;
  localparam int         EV_TIMEOUT  = 3;
  localparam int         EV_W        = 4;
  localparam int         ST_MODE_LSB = 0;
  localparam int         ST_FLAG_LSB = 4;
  localparam int         ST_CMP_LSB  = 12;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {MODE_STARTUP, MODE_SAVE, MODE_OPER, MODE_SHUT} bpm_mode_t;

  typedef struct packed {
    logic cs_above_ref;
    logic ref_above_2v0;
    logic ref_above_3v0;
    logic above_reg_off;
    logic above_reg_on;
    logic above_protect;
    logic above_ref_off;
    logic above_turn_off;
    logic above_save;
    logic above_turn_on;
  } bpm_cmp_t;

  typedef struct packed {
    logic heat;
    logic power_factor;
    logic high;
    logic low;
  } bpm_gate_t;

  localparam int CMP_W  = $bits(bpm_cmp_t);
  localparam int GATE_W = $bits(bpm_gate_t);

endpackage : bpm_pkg

// >>> verilog/bpm_power_mode_controller.sv
// Our own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module bpm_power_mode_controller
  import bpm_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire bpm_cmp_t    cmp_i,
  input  wire bpm_gate_t   gate_in_i,
  output bpm_gate_t        gate_out_o,
  output logic             current_fault_out_o,
  output logic             startup_source_on_o,
  output logic             ref_enable_o,
  output logic             ref_high_current_o,
  output logic             ref_sink_on_o,
  output logic             supply_regulation_switch_o,
  output logic             bootstrap_on_o,
  output logic             boot_reverse_block_o,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);

  // ==========================================================================
  // Input synchronizers
  // Comparators and gate inputs are asynchronous to clk_i; the first stage
  // is read only by the second.
  localparam int SYN_W = CMP_W + GATE_W;

  logic [SYN_W-1:0] sync1_r;
  logic [SYN_W-1:0] sync2_r;
  wire logic [SYN_W-1:0] async_in = {gate_in_i, cmp_i};
  bpm_cmp_t         cmp;
  bpm_gate_t        gin;
  bpm_gate_t        gin_prev_r;

  generate
    for (genvar gi = 0; gi < SYN_W; gi++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= async_in[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  assign cmp = bpm_cmp_t'(sync2_r[CMP_W-1:0]);
  assign gin = bpm_gate_t'(sync2_r[SYN_W-1:CMP_W]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gin_prev_r <= '0;
    end else begin
      gin_prev_r <= gin;
    end
  end

  function automatic logic fell(input logic prev, input logic now);
    fell = prev & ~now;
  endfunction : fell

  logic low_fall;
  logic low_edge;
  logic high_fall;

  assign low_fall  = fell(gin_prev_r.low, gin.low);
  assign low_edge  = low_fall | fell(gin.low, gin_prev_r.low);
  assign high_fall = fell(gin_prev_r.high, gin.high);

  // ==========================================================================
  // Dwell and timeout counters
  logic [CNT_W-1:0] dwell_r;
  logic [CNT_W-1:0] idle_r;
  logic             dwell_done;
  logic             idle_expired;
  bpm_mode_t        mode_r;
  bpm_mode_t        mode_nxt;

  localparam logic [CNT_W-1:0] DWELL_LIM   = CNT_W'(DWELL_CYC);
  localparam logic [CNT_W-1:0] TIMEOUT_LIM = CNT_W'(TIMEOUT_CYCLES);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dwell_r <= '0;
    end else if (mode_r != MODE_SAVE) begin
      dwell_r <= '0;
    end else if (dwell_r < DWELL_LIM) begin
      dwell_r <= dwell_r + 1'b1;
    end
  end

  assign dwell_done = (dwell_r >= DWELL_LIM);

  // Switching absence count
  // Saturates one past the limit so "more than" the timeout is seen.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle_r <= '0;
    end else if (mode_r != MODE_OPER || low_edge) begin
      idle_r <= '0;
    end else if (idle_r <= TIMEOUT_LIM) begin
      idle_r <= idle_r + 1'b1;
    end
  end

  assign idle_expired = (idle_r > TIMEOUT_LIM);

  // ==========================================================================
  // Mode machine
  // Mode transitions
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      MODE_STARTUP: begin
        if (cmp.above_turn_on) begin
          mode_nxt = MODE_SAVE;
        end
      end
      MODE_SAVE: begin
        if (!cmp.above_ref_off) begin
          mode_nxt = MODE_STARTUP;
        end else if (dwell_done && cmp.ref_above_3v0 && high_fall) begin
          mode_nxt = MODE_OPER;
        end
      end
      MODE_OPER: begin
        if (!cmp.above_turn_off || !cmp.ref_above_2v0) begin
          mode_nxt = MODE_SHUT;
        end else if (idle_expired) begin
          mode_nxt = MODE_SAVE;
        end
      end
      MODE_SHUT: begin
        if (cmp.above_turn_on) begin
          mode_nxt = MODE_SAVE;
        end else if (!cmp.above_ref_off) begin
          mode_nxt = MODE_STARTUP;
        end
      end
      default: begin
        mode_nxt = MODE_STARTUP;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= MODE_STARTUP;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // ==========================================================================
  // Start-up source and reference
  logic startup_src_r;
  logic ref_en_r;
  logic ref_hi_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      startup_src_r <= 1'b1;
    end else begin
      case (mode_nxt)
        MODE_STARTUP: startup_src_r <= 1'b1;
        MODE_SHUT:    startup_src_r <= 1'b1;
        MODE_OPER:    startup_src_r <= 1'b0;
        MODE_SAVE: begin
          if (cmp.above_turn_on) begin
            startup_src_r <= 1'b0;
          end else if (!cmp.above_save) begin
            startup_src_r <= 1'b1;
          end
        end
        default:      startup_src_r <= 1'b1;
      endcase
    end
  end

  // Reference gated by level
  // Shutdown keeps the reference only while supply stays above the level.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_en_r <= 1'b0;
      ref_hi_r <= 1'b0;
    end else begin
      ref_en_r <= (mode_nxt != MODE_STARTUP) && cmp.above_ref_off;
      ref_hi_r <= (mode_nxt == MODE_OPER);
    end
  end

  // ==========================================================================
  // Two-point regulator
  logic reg_sw_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_sw_r <= 1'b0;
    end else if (mode_r != MODE_OPER) begin
      reg_sw_r <= 1'b0;
    end else if (cmp.above_protect) begin
      reg_sw_r <= 1'b1;
    end else if (low_fall) begin
      if (cmp.above_reg_on) begin
        reg_sw_r <= 1'b1;
      end else if (!cmp.above_reg_off) begin
        reg_sw_r <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Overcurrent latch
  // Held clear whenever mode_r is not MODE_OPER; uses mode_r, not mode_nxt.
  logic ocp_r;
  logic ocp_release;

  assign ocp_release = !gin.low && !gin.high && !cmp.cs_above_ref;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ocp_r <= 1'b0;
    end else if (mode_r != MODE_OPER) begin
      ocp_r <= 1'b0;
    end else if (cmp.cs_above_ref) begin
      ocp_r <= 1'b1;
    end else if (ocp_release) begin
      ocp_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Drivers
  logic [1:0] ctrl_r;
  logic       interlock;
  logic       drv_en;
  bpm_gate_t  gate_r;
  logic       boot_r;
  logic       boot_block_r;

  assign interlock = gin.high && gin.low;
  assign drv_en    = (mode_r == MODE_OPER) && ctrl_r[CTRL_DRV_ALLOW];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_r <= '0;
    end else if (!drv_en) begin
      gate_r <= '0;
    end else begin
      gate_r.power_factor <= gin.power_factor;
      gate_r.heat         <= gin.heat && ctrl_r[CTRL_HEAT_ALLOW];
      gate_r.low          <= gin.low && !interlock && !ocp_r && !cmp.cs_above_ref;
      gate_r.high         <= gin.high && !interlock && !ocp_r && !cmp.cs_above_ref;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_r       <= 1'b0;
      boot_block_r <= 1'b1;
    end else begin
      boot_r       <= drv_en && gin.low && !interlock && !ocp_r && !cmp.cs_above_ref;
      boot_block_r <= 1'b1;
    end
  end

  assign gate_out_o                 = gate_r;
  assign current_fault_out_o        = ocp_r;
  assign startup_source_on_o        = startup_src_r;
  assign ref_enable_o               = ref_en_r;
  assign ref_high_current_o         = ref_hi_r;
  assign ref_sink_on_o              = !ref_en_r;
  assign supply_regulation_switch_o = reg_sw_r;
  assign bootstrap_on_o             = boot_r;
  assign boot_reverse_block_o       = boot_block_r;

  // ==========================================================================
  // Sticky events
  logic            ack_r;
  logic            wr_commit;
  logic [EV_W-1:0] ev_r;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;

  assign wr_commit = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;

  always_comb begin
    ev_set              = '0;
    ev_set[EV_OCP]      = (mode_r == MODE_OPER) && cmp.cs_above_ref && !ocp_r;
    ev_set[EV_LOCK]     = drv_en && interlock;
    ev_set[EV_SHUT]     = (mode_r == MODE_OPER) && (mode_nxt == MODE_SHUT);
    ev_set[EV_TIMEOUT]  = (mode_r == MODE_OPER) && (mode_nxt == MODE_SAVE);
    ev_clr              = '0;
    if (wr_commit && (wb_adr_i == ADDR_EVENTS) && wb_sel_i[0]) begin
      ev_clr = wb_dat_i[EV_W-1:0];
    end
  end

  // Write-one-to-clear; a new event in the clearing cycle survives.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_r <= '0;
    end else begin
      ev_r <= (ev_r & ~ev_clr) | ev_set;
    end
  end

  // ==========================================================================
  // Wishbone slave
  // One wait state: ack rises the cycle after the strobe, and writes land
  // on the edge where the master sees ack.
  logic [31:0] rd_data;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RESET;
    end else if (wr_commit && (wb_adr_i == ADDR_CTRL) && wb_sel_i[0]) begin
      ctrl_r <= wb_dat_i[1:0];
    end
  end

  always_comb begin
    rd_data = '0;
    case (wb_adr_i)
      ADDR_CTRL: begin
        rd_data[1:0] = ctrl_r;
      end
      ADDR_STATUS: begin
        rd_data[ST_MODE_LSB +: 2]        = mode_r;
        rd_data[ST_FLAG_LSB +: 8]        = {boot_r, reg_sw_r, ref_hi_r, ref_en_r,
                                            startup_src_r, ocp_r, interlock, drv_en};
        rd_data[ST_CMP_LSB +: CMP_W]     = cmp;
      end
      ADDR_EVENTS: begin
        rd_data[EV_W-1:0] = ev_r;
      end
      ADDR_IDLE: begin
        rd_data[CNT_W-1:0] = idle_r;
      end
      default: begin
        rd_data = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (wb_cyc_i && wb_stb_i && !ack_r) begin
      wb_dat_o <= rd_data;
    end
  end

  assign wb_ack_o = ack_r;

endmodule : bpm_power_mode_controller
